// ==== rtl/rld_deser_out.sv ====
// deserializer framing, lock control and gated parallel outputs
// Notes on behaviour
// - parallel words are launched with the rising recovered clock edge when edge select is high, falling when low.
// - powerdown low stops the recovery loop and floats recovered clock, lock and data outputs.
// - the active-low lock output is low while locked and high while unlocked.
// - output enable low floats data and recovered clock, and lock subject to its own timing.
// - the recovered clock runs at the word rate, is framed on the embedded clock bits and strobes the data.
// - if locked when output enable falls, lock floats on the next reference clock rising edge.
// - if unlocked when output enable falls, lock keeps driving high and goes low when lock comes.
// - loss of lock is signalled after four consecutive invalid words (bad clock bits or an equal-leg bit), or at once on a resync write or on powerdown.
// - data outputs stay floating after power-up until a lock has been reached.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module rld_deser_out
    import rld_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // serial link and reference
    input wire logic SERIAL_IN_POS,
    input wire logic SERIAL_IN_NEG,
    input wire logic LOCAL_REFERENCE_CLOCK,
    // control pins
    input wire logic EDGE_SELECT_RISING,
    input wire logic OUTPUT_ENABLE,
    input wire logic POWERDOWN_N,
    // parallel side
    output rld_par_out_s PAR_OUT,
    // register port
    input rld_bus_req_s BUS_REQ,
    output logic [31:0] BUS_RDATA,
    output logic IRQ
);
    logic [NSYNC-1:0] pin_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic pos_s, neg_s, ref_s, edge_s, ren_s, active;
    logic ref_d1_q, ren_d1_q, active_d1_q;
    logic line_ok, rx_bit;
    logic [11:0] sh_q, sh_d;
    logic bad_acc_q;
    logic frame_valid, at_last;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    rld_state_e state_q;
    logic [2:0] good_q, bad_q;
    logic locked, locked_d1_q;
    logic [WORD_W-1:0] word_rx, word_q, out_q;
    logic rclk_q, seen_lock_q;
    logic word_oe_n_q, rclk_oe_n_q, lock_n_q, lock_oe_n_q;
    logic tri_pend_q, lock_tri_q;
    logic [1:0] ctrl_q;
    logic resync_q;
    logic [INT_W-1:0] int_stat_q, int_mask_q, int_ev;
    logic [31:0] rd_data_q;
    logic hist_rd_q;
    logic hist_we;
    logic [HIST_AW-1:0] wp_q, hist_raddr;
    logic [WORD_W-1:0] hist_rdata;
    logic wr_ctrl, wr_stat, wr_mask, lock_lost_ev;

    // every pin crosses two flops before use
    assign pin_in = {SERIAL_IN_POS, SERIAL_IN_NEG, LOCAL_REFERENCE_CLOCK,
                     EDGE_SELECT_RISING, OUTPUT_ENABLE, POWERDOWN_N};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign pos_s = sync2_q[5];
    assign neg_s = sync2_q[4];
    assign ref_s = sync2_q[3];
    assign edge_s = sync2_q[2];
    assign ren_s = sync2_q[1];
    assign active = sync2_q[0];

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ref_d1_q <= 1'b0;
            ren_d1_q <= 1'b0;
            active_d1_q <= 1'b0;
            locked_d1_q <= 1'b0;
        end else begin
            ref_d1_q <= ref_s;
            ren_d1_q <= ren_s;
            active_d1_q <= active;
            locked_d1_q <= locked;
        end
    end

    // equal legs mean an idle or broken line; such a bit spoils its word
    assign line_ok = pos_s ^ neg_s;
    assign rx_bit = pos_s;
    assign sh_d = {sh_q[10:0], rx_bit};
    assign at_last = (cnt_q == CNT_LAST);
    // frame is valid when both embedded clock bits sit where expected and no bit of the word had equal legs
    assign frame_valid = sh_d[11] & ~sh_d[0] & ~bad_acc_q & line_ok;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !active) begin
            sh_q <= 12'h000;
            bad_acc_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            bad_acc_q <= at_last ? 1'b0 : (bad_acc_q | ~line_ok);
        end
    end

    // bit counter; in hunt a valid frame re-aligns it
    always_comb begin
        if (!active) begin
            cnt_d = CNT_RST;
        end else if (state_q == ST_HUNT && frame_valid) begin
            cnt_d = CNT_RST;
        end else if (at_last) begin
            cnt_d = CNT_RST;
        end else begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // lock state machine
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !active || resync_q) begin
            state_q <= ST_HUNT;
            good_q <= CNT3_RST;
            bad_q <= CNT3_RST;
        end else begin
            case (state_q)
                ST_HUNT: begin
                    if (frame_valid) begin
                        state_q <= ST_VERIFY;
                        good_q <= CNT3_RST;
                    end
                end
                ST_VERIFY: begin
                    if (at_last) begin
                        if (!frame_valid) begin
                            state_q <= ST_HUNT;
                        end else if (good_q + 3'h1 == LOCK_GOOD_WORDS) begin
                            state_q <= ST_LOCKED;
                            bad_q <= CNT3_RST;
                        end else begin
                            good_q <= good_q + 3'h1;
                        end
                    end
                end
                ST_LOCKED: begin
                    if (at_last) begin
                        if (frame_valid) begin
                            bad_q <= CNT3_RST;
                        end else if (bad_q + 3'h1 == LOSS_BAD_WORDS) begin
                            state_q <= ST_HUNT;
                        end else begin
                            bad_q <= bad_q + 3'h1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_HUNT;
                end
            endcase
        end
    end

    assign locked = (state_q == ST_LOCKED);

    // first data bit arrives first, so it lands in the oldest data position
    generate
        for (gi = 0; gi < WORD_W; gi++) begin : g_rev
            assign word_rx[gi] = sh_d[10-gi];
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            word_q <= WORD_RST;
        end else if (at_last && frame_valid && state_q != ST_HUNT) begin
            word_q <= word_rx;
        end
    end

    // word-rate clock plus output launch on the chosen edge; one word per period
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !active) begin
            rclk_q <= 1'b0;
            out_q <= WORD_RST;
        end else begin
            rclk_q <= (cnt_d < CNT_FALL);
            if (cnt_d == (edge_s ? CNT_RISE : CNT_FALL)) begin
                out_q <= word_q;
            end
        end
    end

    // data stay floating from power-up until the first lock
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !active) begin
            seen_lock_q <= 1'b0;
        end else if (locked) begin
            seen_lock_q <= 1'b1;
        end else if (lock_lost_ev && bad_acc_q) begin
            seen_lock_q <= 1'b0;
        end
    end

    // lock pin float decision is taken once, at the fall of output enable
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !active || ren_s) begin
            tri_pend_q <= 1'b0;
            lock_tri_q <= 1'b0;
        end else if (ren_d1_q) begin
            tri_pend_q <= locked;
        end else if (tri_pend_q && ref_s && !ref_d1_q) begin
            tri_pend_q <= 1'b0;
            lock_tri_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            word_oe_n_q <= 1'b1;
            rclk_oe_n_q <= 1'b1;
            lock_oe_n_q <= 1'b1;
            lock_n_q <= 1'b1;
        end else begin
            word_oe_n_q <= ~(active & ren_s & seen_lock_q);
            rclk_oe_n_q <= ~(active & ren_s);
            lock_oe_n_q <= ~(active & ~lock_tri_q);
            lock_n_q <= ~locked;
        end
    end

    assign PAR_OUT.word = out_q;
    assign PAR_OUT.word_oe_n = word_oe_n_q;
    assign PAR_OUT.rclk = rclk_q;
    assign PAR_OUT.rclk_oe_n = rclk_oe_n_q;
    assign PAR_OUT.lock_n = lock_n_q;
    assign PAR_OUT.lock_oe_n = lock_oe_n_q;

    // history so software can tell the sender what to resend after a loss
    assign hist_we = at_last && frame_valid && locked && !ctrl_q[1];
    assign hist_raddr = wp_q - 3'h1 - BUS_REQ.addr[4:2];

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            wp_q <= 3'h0;
        end else if (hist_we) begin
            wp_q <= wp_q + 3'h1;
        end
    end

    rld_word_hist u_hist (
        .clk(CLK_SYS),
        .wr_en(hist_we),
        .wr_addr(wp_q),
        .wr_data(word_rx),
        .rd_addr(hist_raddr),
        .rd_data(hist_rdata)
    );

    // register writes
    assign wr_ctrl = BUS_REQ.wr && BUS_REQ.addr == OFS_CTRL;
    assign wr_stat = BUS_REQ.wr && BUS_REQ.addr == OFS_INT_STAT;
    assign wr_mask = BUS_REQ.wr && BUS_REQ.addr == OFS_INT_MASK;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ctrl_q <= CTRL_RST;
            resync_q <= 1'b0;
            int_mask_q <= INT_RST;
        end else begin
            resync_q <= wr_ctrl & BUS_REQ.wdata[0];
            if (wr_ctrl) begin
                ctrl_q <= {BUS_REQ.wdata[1], 1'b0};
            end
            if (wr_mask) begin
                int_mask_q <= BUS_REQ.wdata[INT_W-1:0];
            end
        end
    end

    // events; a new event wins over a simultaneous write-one clear
    assign lock_lost_ev = locked_d1_q & ~locked;
    always_comb begin
        int_ev = INT_RST;
        int_ev[INT_LOCK_GAIN] = locked & ~locked_d1_q;
        int_ev[INT_LOCK_LOST] = lock_lost_ev;
        int_ev[INT_BAD_WORD] = locked & at_last & ~frame_valid;
        int_ev[INT_POWERDOWN_N] = active_d1_q & ~active;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            int_stat_q <= INT_RST;
        end else begin
            int_stat_q <= (int_stat_q & ~(wr_stat ? BUS_REQ.wdata[INT_W-1:0] : INT_RST))
                          | int_ev;
        end
    end

    assign IRQ = |(int_stat_q & int_mask_q);

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rd_data_q <= 32'h0000_0000;
            hist_rd_q <= 1'b0;
        end else begin
            rd_data_q <= 32'h0000_0000;
            hist_rd_q <= BUS_REQ.rd && BUS_REQ.addr[7:5] == OFS_HIST_PAGE;
            if (BUS_REQ.rd) begin
                case (BUS_REQ.addr)
                    OFS_CTRL: rd_data_q <= {30'h0000_0000, ctrl_q};
                    OFS_STATUS: begin
                        rd_data_q <= {20'h0_0000, good_q, bad_q, active, ren_s,
                                      state_q, seen_lock_q, locked};
                    end
                    OFS_INT_STAT: rd_data_q <= {28'h000_0000, int_stat_q};
                    OFS_INT_MASK: rd_data_q <= {28'h000_0000, int_mask_q};
                    OFS_LAST_WORD: rd_data_q <= {22'h00_0000, word_q};
                    default: rd_data_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign BUS_RDATA = hist_rd_q ? {22'h00_0000, hist_rdata} : rd_data_q;
endmodule

// ==== rtl/rld_pkg.sv ====
// package: constants, states and carriers of the random lock deserializer output block
package rld_pkg;
    // word framing on the serial line: clock bit 1, ten data bits, clock bit 0
    localparam int WORD_W = 10;
    localparam int CNT_W = 4;
    localparam logic [3:0] CNT_LAST = 4'hB;
    localparam logic [3:0] CNT_RISE = 4'h0;
    localparam logic [3:0] CNT_FALL = 4'h6;
    localparam logic [3:0] CNT_RST = 4'h0;
    // word counts for lock acquisition and loss
    localparam logic [2:0] LOCK_GOOD_WORDS = 3'h4;
    localparam logic [2:0] LOSS_BAD_WORDS = 3'h4;
    // history of received words, enough for the five to resend after a loss
    localparam int HIST_AW = 3;
    localparam int HIST_DEPTH = 8;
    // synchronised pins
    localparam int NSYNC = 6;
    // register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0C;
    localparam logic [7:0] OFS_LAST_WORD = 8'h10;
    localparam logic [2:0] OFS_HIST_PAGE = 3'h1;
    // interrupt bits
    localparam int INT_W = 4;
    localparam int INT_LOCK_GAIN = 0;
    localparam int INT_LOCK_LOST = 1;
    localparam int INT_BAD_WORD = 2;
    localparam int INT_POWERDOWN_N = 3;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [3:0] INT_RST = 4'h0;
    localparam logic [9:0] WORD_RST = 10'h000;
    localparam logic [2:0] CNT3_RST = 3'h0;

    typedef enum logic [1:0] {
        ST_HUNT = 2'b00,
        ST_VERIFY = 2'b01,
        ST_LOCKED = 2'b10
    } rld_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } rld_bus_req_s;

    typedef struct packed {
        logic [9:0] word;
        logic word_oe_n;
        logic rclk;
        logic rclk_oe_n;
        logic lock_n;
        logic lock_oe_n;
    } rld_par_out_s;
endpackage

// ==== rtl/rld_word_hist.sv ====
// memory of the most recent received words, registered read
`timescale 1ns/10ps
module rld_word_hist
    import rld_pkg::*;
(
    // clock
    input wire logic clk,
    // write side
    input wire logic wr_en,
    input wire logic [HIST_AW-1:0] wr_addr,
    input wire logic [WORD_W-1:0] wr_data,
    // read side
    input wire logic [HIST_AW-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data
);
    logic [WORD_W-1:0] mem [HIST_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ==== verification/rld_ser_model.sv ====
// serializer model driving the differential serial link
`timescale 1ns/10ps
module rld_ser_model (
    // clock and control
    input wire logic clk,
    input wire logic en,
    input wire logic rewind,
    // serial pair and word in flight
    output logic pos,
    output logic neg,
    output logic [9:0] data_q
);
    logic [3:0] cnt_q;
    logic bit_v;
    initial begin
        cnt_q = 4'h0;
        // only bit 9 alternates, so no phase but the true one carries both clock bits
        data_q = 10'h1FF;
        pos = 1'b0;
        neg = 1'b1;
    end
    // framing keeps running while the line is broken, so the word rate never slips
    always @(posedge clk) begin
        cnt_q <= (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
        // two words alternate, so five words back is the other one
        if (rewind) data_q <= data_q ^ 10'h200;
        else if (cnt_q == 4'hB) data_q <= data_q ^ 10'h200;
        bit_v = (cnt_q == 4'h0) ? 1'b1 : (cnt_q == 4'hB) ? 1'b0 : data_q[cnt_q - 4'h1];
        if (en) begin
            pos <= bit_v;
            neg <= ~bit_v;
        end else begin
            // broken line: both legs equal and toggling, never a stale valid bit
            pos <= ~pos;
            neg <= ~pos;
        end
    end
endmodule

// ==== verification/rld_deser_out_sva.sv ====
// assertion checker for the deserializer output block
`timescale 1ns/10ps
module rld_deser_out_chk
    import rld_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // pins
    input wire logic SERIAL_IN_POS,
    input wire logic SERIAL_IN_NEG,
    input wire logic EDGE_SELECT_RISING,
    input wire logic OUTPUT_ENABLE,
    input wire logic POWERDOWN_N,
    // parallel side
    input wire rld_par_out_s PAR_OUT
);
    logic [5:0] bad_run_q;
    logic [3:0] pd_sh_q;
    logic seen_q;
    always_ff @(posedge CLK_SYS) begin
        if (SERIAL_IN_POS != SERIAL_IN_NEG) bad_run_q <= 6'h00;
        else if (bad_run_q != 6'h3F) bad_run_q <= bad_run_q + 6'h01;
    end
    always_ff @(posedge CLK_SYS) pd_sh_q <= {pd_sh_q[2:0], POWERDOWN_N & RST_N};
    // only reset clears it, so the check is weaker after a powerdown
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) seen_q <= 1'b0;
        else if (!PAR_OUT.lock_n) seen_q <= 1'b1;
    end
    reset_float_a: assert property (@(posedge CLK_SYS)
        !RST_N |=> PAR_OUT.word_oe_n && PAR_OUT.rclk_oe_n && PAR_OUT.lock_oe_n && PAR_OUT.lock_n)
        else $error("outputs not floating after reset");
    powerdown_n_float_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !POWERDOWN_N [*3] |=> PAR_OUT.word_oe_n && PAR_OUT.rclk_oe_n && PAR_OUT.lock_oe_n
        && !PAR_OUT.rclk)
        else $error("outputs driven in powerdown");
    oe_float_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !OUTPUT_ENABLE [*3] |=> PAR_OUT.word_oe_n && PAR_OUT.rclk_oe_n)
        else $error("word or clock driven with enable low");
    rclk_period_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N || !POWERDOWN_N)
        $rose(PAR_OUT.rclk) && !PAR_OUT.lock_n |->
        PAR_OUT.rclk [*6] ##1 !PAR_OUT.rclk [*6] ##1 PAR_OUT.rclk)
        else $error("recovered clock not at word rate");
    word_strobe_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $changed(PAR_OUT.word) && !PAR_OUT.word_oe_n && !$past(PAR_OUT.word_oe_n) |->
        ($past(EDGE_SELECT_RISING, 3) ? $rose(PAR_OUT.rclk) : $fell(PAR_OUT.rclk)))
        else $error("word changed off the selected strobe edge");
    lock_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(PAR_OUT.lock_n) && (&pd_sh_q) |-> bad_run_q >= 6'h25)
        else $error("lock lost before four bad words");
    lock_float_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(OUTPUT_ENABLE) && !PAR_OUT.lock_n |-> ##[2:20] PAR_OUT.lock_oe_n)
        else $error("lock output not floated");
    lock_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(OUTPUT_ENABLE) && PAR_OUT.lock_n && !PAR_OUT.lock_oe_n |-> !PAR_OUT.lock_oe_n [*8])
        else $error("unlocked lock output stopped driving");
    word_float_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !PAR_OUT.word_oe_n |-> seen_q || !PAR_OUT.lock_n)
        else $error("word driven before any lock");
endmodule
bind rld_deser_out rld_deser_out_chk rld_deser_out_chk_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .SERIAL_IN_POS(SERIAL_IN_POS), .SERIAL_IN_NEG(SERIAL_IN_NEG),
    .EDGE_SELECT_RISING(EDGE_SELECT_RISING), .OUTPUT_ENABLE(OUTPUT_ENABLE),
    .POWERDOWN_N(POWERDOWN_N), .PAR_OUT(PAR_OUT));

// ==== verification/tb_rld_deser_out.sv ====
// self-checking bench for the deserializer output block
`timescale 1ns/10ps
module tb_rld_deser_out
    import rld_pkg::*;
;
    logic CLK_SYS, RST_N, LOCAL_REFERENCE_CLOCK, EDGE_SELECT_RISING, OUTPUT_ENABLE, POWERDOWN_N;
    logic en, rewind, pos, neg, irq;
    logic [9:0] sw;
    logic [31:0] rdata;
    rld_par_out_s par;
    rld_bus_req_s req;
    int miscompares, comparisons, cyc;
    initial begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end
    // free-running reference, unrelated to the system clock
    initial begin
        LOCAL_REFERENCE_CLOCK = 1'b0;
        forever #87 LOCAL_REFERENCE_CLOCK = ~LOCAL_REFERENCE_CLOCK;
    end
    rld_deser_out rld_deser_out_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SERIAL_IN_POS(pos),
        .SERIAL_IN_NEG(neg), .LOCAL_REFERENCE_CLOCK(LOCAL_REFERENCE_CLOCK),
        .EDGE_SELECT_RISING(EDGE_SELECT_RISING), .OUTPUT_ENABLE(OUTPUT_ENABLE),
        .POWERDOWN_N(POWERDOWN_N), .PAR_OUT(par), .BUS_REQ(req), .BUS_RDATA(rdata), .IRQ(irq));
    rld_ser_model rld_ser_model_inst (.clk(CLK_SYS), .en(en), .rewind(rewind), .pos(pos),
        .neg(neg), .data_q(sw));
    task automatic print_verdict();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge CLK_SYS);
        req <= '0;
        #1;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK_SYS);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge CLK_SYS);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic wait_lock(input logic e);
        int i;
        for (i = 0; i < 3000 && par.lock_n !== e; i++) cyc_n(1);
        chk(32'(par.lock_n), 32'(e));
    endtask
    task automatic t_reset();
        logic [31:0] d;
        chk({28'h0, par.lock_n, par.word_oe_n, par.rclk_oe_n, par.lock_oe_n}, 32'hC);
        bus_rd(OFS_INT_MASK, d);
        chk(d, 32'h0);
        bus_rd(8'h80, d);
        chk(d, 32'h0);
    endtask
    task automatic t_lock();
        logic [31:0] d;
        @(posedge CLK_SYS) en <= 1'b1;
        wait_lock(1'b0);
        cyc_n(2);
        chk({29'h0, par.word_oe_n, par.rclk_oe_n, par.lock_oe_n}, 32'h0);
        bus_rd(OFS_INT_STAT, d);
        chk(d & 32'h1, 32'h1);
        bus_wr(OFS_INT_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        bus_wr(OFS_INT_STAT, 32'h1);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_words(input logic sel);
        logic [9:0] w;
        int i;
        @(posedge CLK_SYS) EDGE_SELECT_RISING <= sel;
        cyc_n(30);
        w = par.word;
        for (i = 0; i < 20 && par.word === w; i++) cyc_n(1);
        chk(32'(par.rclk), 32'(sel));
        w = par.word;
        cyc_n(11);
        chk(32'(par.word), 32'(w));
        cyc_n(1);
        chk(32'(par.word), 32'(w ^ 10'h200));
        chk(32'(par.rclk), 32'(sel));
    endtask
    task automatic t_hist();
        logic [31:0] d, h;
        bus_wr(OFS_CTRL, 32'h2);
        bus_rd(OFS_CTRL, d);
        chk(d, 32'h2);
        bus_rd(8'h20, h);
        bus_rd(8'h24, d);
        chk(d, h ^ 32'h200);
        chk(h & 32'hFFFF_FDFF, 32'h1FF);
        bus_wr(OFS_CTRL, 32'h0);
    endtask
    task automatic t_loss();
        logic [31:0] d;
        // 25 broken cycles touch three words at most
        @(posedge CLK_SYS) en <= 1'b0;
        cyc_n(24);
        @(posedge CLK_SYS) en <= 1'b1;
        cyc_n(40);
        chk(32'(par.lock_n), 32'h0);
        @(posedge CLK_SYS) en <= 1'b0;
        cyc_n(80);
        chk(32'(par.lock_n), 32'h1);
        bus_rd(OFS_INT_STAT, d);
        chk(d & 32'h2, 32'h2);
        @(posedge CLK_SYS) en <= 1'b1;
        wait_lock(1'b0);
        @(posedge CLK_SYS) rewind <= 1'b1;
        @(posedge CLK_SYS) rewind <= 1'b0;
    endtask
    task automatic t_oe_lk();
        @(posedge CLK_SYS) OUTPUT_ENABLE <= 1'b0;
        cyc_n(4);
        chk({30'h0, par.word_oe_n, par.rclk_oe_n}, 32'h3);
        cyc_n(20);
        chk(32'(par.lock_oe_n), 32'h1);
        @(posedge CLK_SYS) OUTPUT_ENABLE <= 1'b1;
        cyc_n(4);
        chk({29'h0, par.word_oe_n, par.rclk_oe_n, par.lock_oe_n}, 32'h0);
    endtask
    task automatic t_oe_ul();
        @(posedge CLK_SYS) en <= 1'b0;
        cyc_n(80);
        @(posedge CLK_SYS) OUTPUT_ENABLE <= 1'b0;
        cyc_n(20);
        chk({30'h0, par.lock_oe_n, par.lock_n}, 32'h1);
        @(posedge CLK_SYS) en <= 1'b1;
        wait_lock(1'b0);
        chk({30'h0, par.lock_oe_n, par.word_oe_n}, 32'h1);
        @(posedge CLK_SYS) OUTPUT_ENABLE <= 1'b1;
    endtask
    task automatic t_powerdown_n();
        logic [31:0] d;
        @(posedge CLK_SYS) POWERDOWN_N <= 1'b0;
        cyc_n(4);
        chk({28'h0, par.rclk, par.word_oe_n, par.rclk_oe_n, par.lock_oe_n}, 32'h7);
        bus_rd(OFS_INT_STAT, d);
        chk(d & 32'h8, 32'h8);
        @(posedge CLK_SYS) POWERDOWN_N <= 1'b1;
        cyc_n(4);
        chk(32'(par.word_oe_n), 32'h1);
        wait_lock(1'b0);
    endtask
    initial begin
        RST_N = 1'b0;
        POWERDOWN_N = 1'b1;
        OUTPUT_ENABLE = 1'b1;
        EDGE_SELECT_RISING = 1'b1;
        en = 1'b0;
        rewind = 1'b0;
        req = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (6) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        cyc_n(4);
        t_reset();
        t_lock();
        t_words(1'b1);
        t_words(1'b0);
        t_hist();
        t_loss();
        t_oe_lk();
        t_oe_ul();
        t_powerdown_n();
        print_verdict();
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge CLK_SYS);
            cyc++;
            if (cyc == 20000) begin
                miscompares++;
                print_verdict();
            end
        end
    end
endmodule
